/* File: tofc_pkg.sv */
// package: register map, field layout and reset values of the timer configuration block
package tofc_pkg;
	localparam logic [7:0]  ADDR_TIMER_CONFIG    = 8'h00;
	localparam logic [7:0]  ADDR_FAULT_POLARITY  = 8'h04;
	localparam logic [7:0]  ADDR_SYNC_CONFIG     = 8'h08;
	localparam logic [7:0]  ADDR_CONTROL         = 8'h0C;
	localparam logic [7:0]  ADDR_IRQ_STATUS      = 8'h10;
	localparam logic [7:0]  ADDR_IRQ_MASK        = 8'h14;
	// timer_config field positions
	localparam int          CONF_RATIO_LSB       = 0;
	localparam int          CONF_RATIO_W         = 5;
	localparam int          CONF_HALT_LSB        = 6;
	localparam int          CONF_HALT_W          = 2;
	localparam int          CONF_EXT_TB_BIT      = 9;
	localparam int          CONF_TB_OUT_BIT      = 10;
	localparam int          FAULT_N              = 4;
	localparam int          SYNC_LOW_W           = 21;
	// control register bits
	localparam int          CTRL_WRITE_PROTECT_DISABLE_BIT       = 0;
	localparam int          CTRL_OVF_BIT         = 1;
	// interrupt status bits
	localparam int          IRQ_W                = 3;
	localparam int          IRQ_OVF_FLAG_BIT     = 0;
	localparam int          IRQ_FAULT_BIT        = 1;
	localparam int          IRQ_EXT_TB_BIT       = 2;
	// reset values
	localparam logic [4:0]  RST_RATIO            = 5'h00;
	localparam logic [1:0]  RST_HALT             = 2'h0;
	localparam logic [3:0]  RST_FAULT_POL        = 4'h0;
	localparam logic [20:0] RST_SYNC_LOW         = 21'h000000;
	localparam logic        RST_WRITE_PROTECT_DISABLE            = 1'b0;
	localparam logic [2:0]  RST_IRQ              = 3'h0;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} tofc_bus_req_t;

	typedef struct packed {
		logic       tb_out_en;
		logic       ext_tb_en;
		logic [1:0] halt_sel;
		logic [4:0] ratio;
	} tofc_conf_t;
endpackage : tofc_pkg

/* File: tofc_top.sv */
// module: overflow flag ratio, time base enables, debug halt select, fault polarity
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
module tofc_top (
	input  wire logic                clk,
	input  wire logic                rstn,
	input  wire logic                ce,
	input  wire tofc_pkg::tofc_bus_req_t bus,
	output logic [31:0]              rdata,
	input  wire logic                cnt_overflow,
	input  wire logic                cnt_time_base,
	input  wire logic                ext_time_base_in,
	input  wire logic [3:0]          fault_in,
	output logic                     overflow_flag,
	output logic                     time_base_out,
	output logic                     time_base_sel,
	output logic [1:0]               debug_halt_behaviour,
	output logic [3:0]               fault_active,
	output logic                     irq
);
	// register state
	tofc_pkg::tofc_conf_t conf;
	tofc_pkg::tofc_conf_t next_conf;
	logic [3:0]           fault_pol;
	logic [3:0]           next_fault_pol;
	logic [20:0]          sync_low;
	logic [20:0]          next_sync_low;
	logic                 write_protect_disable;
	logic                 next_write_protect_disable;
	logic [2:0]           irq_status;
	logic [2:0]           next_irq_status;
	logic [2:0]           irq_mask;
	logic [2:0]           next_irq_mask;
	logic [31:0]          next_rdata;
	// overflow skip state
	logic [4:0]           skip_cnt;
	logic [4:0]           next_skip_cnt;
	logic                 next_overflow_flag;
	// pin synchronisers
	logic [3:0]           flt_s1;
	logic [3:0]           flt_s2;
	logic [3:0]           flt_s3;
	logic [3:0]           flt_stable;
	logic [3:0]           next_flt_stable;
	logic                 etb_s1;
	logic                 etb_s2;
	logic                 etb_s3;
	logic                 etb_stable;
	logic                 next_etb_stable;
	logic [3:0]           next_flt_s1;
	logic [3:0]           next_flt_s2;
	logic [3:0]           next_flt_s3;
	logic                 next_etb_s1;
	logic                 next_etb_s2;
	logic                 next_etb_s3;
	// outputs
	logic                 next_time_base_out;
	logic                 next_time_base_sel;
	logic [3:0]           next_fault_active;
	logic                 next_irq;
	logic [1:0]           next_debug_halt_behaviour;
	logic                 ovf_flag_set;
	logic                 etb_edge;

	// write strobe to a given address
	function automatic logic wr_hit(input tofc_pkg::tofc_bus_req_t b, input logic [7:0] a);
		return b.wr && (b.addr == a);
	endfunction : wr_hit

	// register writes and interrupt status
	always_comb begin
		next_conf       = conf;
		next_fault_pol  = fault_pol;
		next_sync_low   = sync_low;
		next_write_protect_disable      = write_protect_disable;
		next_irq_mask   = irq_mask;
		next_irq_status = irq_status;
		if (wr_hit(bus, tofc_pkg::ADDR_TIMER_CONFIG)) begin
			next_conf.ratio     = bus.wdata[tofc_pkg::CONF_RATIO_LSB +: tofc_pkg::CONF_RATIO_W];
			next_conf.halt_sel  = bus.wdata[tofc_pkg::CONF_HALT_LSB +: tofc_pkg::CONF_HALT_W];
			next_conf.ext_tb_en = bus.wdata[tofc_pkg::CONF_EXT_TB_BIT];
			next_conf.tb_out_en = bus.wdata[tofc_pkg::CONF_TB_OUT_BIT];
		end
		if (wr_hit(bus, tofc_pkg::ADDR_FAULT_POLARITY) && write_protect_disable) begin
			next_fault_pol = bus.wdata[tofc_pkg::FAULT_N-1:0];
		end
		if (wr_hit(bus, tofc_pkg::ADDR_SYNC_CONFIG)) begin
			next_sync_low = bus.wdata[tofc_pkg::SYNC_LOW_W-1:0];
		end
		if (wr_hit(bus, tofc_pkg::ADDR_CONTROL)) begin
			next_write_protect_disable = bus.wdata[tofc_pkg::CTRL_WRITE_PROTECT_DISABLE_BIT];
		end
		if (wr_hit(bus, tofc_pkg::ADDR_IRQ_MASK)) begin
			next_irq_mask = bus.wdata[tofc_pkg::IRQ_W-1:0];
		end
		// write one to clear, then new events win
		if (wr_hit(bus, tofc_pkg::ADDR_IRQ_STATUS)) begin
			next_irq_status = irq_status & ~bus.wdata[tofc_pkg::IRQ_W-1:0];
		end
		next_irq_status[tofc_pkg::IRQ_OVF_FLAG_BIT] =
			next_irq_status[tofc_pkg::IRQ_OVF_FLAG_BIT] | ovf_flag_set;
		next_irq_status[tofc_pkg::IRQ_FAULT_BIT] =
			next_irq_status[tofc_pkg::IRQ_FAULT_BIT] | (|next_fault_active);
		next_irq_status[tofc_pkg::IRQ_EXT_TB_BIT] =
			next_irq_status[tofc_pkg::IRQ_EXT_TB_BIT] | etb_edge;
		// level interrupt from unmasked status
		next_irq = |(next_irq_status & next_irq_mask);
	end

	// read data mux, answer in the cycle after the strobe
	always_comb begin
		next_rdata = 32'h00000000;
		if (bus.rd) begin
			unique case (bus.addr)
				tofc_pkg::ADDR_TIMER_CONFIG: begin
					next_rdata[tofc_pkg::CONF_RATIO_LSB +: tofc_pkg::CONF_RATIO_W] = conf.ratio;
					next_rdata[tofc_pkg::CONF_HALT_LSB +: tofc_pkg::CONF_HALT_W]   = conf.halt_sel;
					next_rdata[tofc_pkg::CONF_EXT_TB_BIT] = conf.ext_tb_en;
					next_rdata[tofc_pkg::CONF_TB_OUT_BIT] = conf.tb_out_en;
				end
				tofc_pkg::ADDR_FAULT_POLARITY: next_rdata[tofc_pkg::FAULT_N-1:0] = fault_pol;
				tofc_pkg::ADDR_SYNC_CONFIG:    next_rdata[tofc_pkg::SYNC_LOW_W-1:0] = sync_low;
				tofc_pkg::ADDR_CONTROL: begin
					next_rdata[tofc_pkg::CTRL_WRITE_PROTECT_DISABLE_BIT] = write_protect_disable;
					next_rdata[tofc_pkg::CTRL_OVF_BIT]   = overflow_flag;
				end
				tofc_pkg::ADDR_IRQ_STATUS: next_rdata[tofc_pkg::IRQ_W-1:0] = irq_status;
				tofc_pkg::ADDR_IRQ_MASK:   next_rdata[tofc_pkg::IRQ_W-1:0] = irq_mask;
				default:                   next_rdata = 32'h00000000;
			endcase
		end
	end

	// overflow skip counter and flag pulse
	always_comb begin
		next_skip_cnt      = skip_cnt;
		next_overflow_flag = 1'b0;
		if (cnt_overflow) begin
			if (skip_cnt == 5'h00) begin
				next_overflow_flag = 1'b1;
				next_skip_cnt = conf.ratio;
			end else begin
				next_skip_cnt = skip_cnt - 5'h01;
			end
		end
		ovf_flag_set = next_overflow_flag;
	end

	// agreement of second and third stage, else hold the old level
	function automatic logic settle_bit(input logic s2, input logic s3, input logic held);
		return (s2 == s3) ? s3 : held;
	endfunction : settle_bit

	// fault pin synchroniser, a change counts once two stages agree
	always_comb begin
		next_flt_s1     = fault_in;
		next_flt_s2     = flt_s1;
		next_flt_s3     = flt_s2;
		next_flt_stable = flt_stable;
		for (int i = 0; i < tofc_pkg::FAULT_N; i++) begin
			next_flt_stable[i] = settle_bit(flt_s2[i], flt_s3[i], flt_stable[i]);
		end
	end

	// external time base synchroniser and rising edge detect
	always_comb begin
		next_etb_s1     = ext_time_base_in;
		next_etb_s2     = etb_s1;
		next_etb_s3     = etb_s2;
		next_etb_stable = settle_bit(etb_s2, etb_s3, etb_stable);
		etb_edge        = conf.ext_tb_en & next_etb_stable & ~etb_stable;
	end

	// output values: polarity, time base gating, halt select
	always_comb begin
		next_fault_active         = next_flt_stable ^ fault_pol;
		next_time_base_out        = conf.tb_out_en & cnt_time_base;
		next_time_base_sel        = conf.ext_tb_en & next_etb_stable;
		next_debug_halt_behaviour = next_conf.halt_sel;
	end

	// configuration registers
	always_ff @(posedge clk) begin
		if (!rstn) begin
			conf      <= '{1'b0, 1'b0, tofc_pkg::RST_HALT, tofc_pkg::RST_RATIO};
			fault_pol <= tofc_pkg::RST_FAULT_POL;
			sync_low  <= tofc_pkg::RST_SYNC_LOW;
			write_protect_disable     <= tofc_pkg::RST_WRITE_PROTECT_DISABLE;
		end else if (ce) begin
			conf      <= next_conf;
			fault_pol <= next_fault_pol;
			sync_low  <= next_sync_low;
			write_protect_disable     <= next_write_protect_disable;
		end
	end

	// interrupt status, mask and level output
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_status <= tofc_pkg::RST_IRQ;
			irq_mask   <= tofc_pkg::RST_IRQ;
			irq        <= 1'b0;
		end else if (ce) begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			irq        <= next_irq;
		end
	end

	// read data, zero unless a read was taken
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rdata <= 32'h00000000;
		end else if (ce) begin
			rdata <= next_rdata;
		end
	end

	// overflow skip counter and flag pulse
	always_ff @(posedge clk) begin
		if (!rstn) begin
			skip_cnt      <= 5'h00;
			overflow_flag <= 1'b0;
		end else if (ce) begin
			skip_cnt      <= next_skip_cnt;
			overflow_flag <= next_overflow_flag;
		end
	end

	// fault pin synchroniser stages
	always_ff @(posedge clk) begin
		if (!rstn) begin
			flt_s1     <= 4'h0;
			flt_s2     <= 4'h0;
			flt_s3     <= 4'h0;
			flt_stable <= 4'h0;
		end else if (ce) begin
			flt_s1     <= next_flt_s1;
			flt_s2     <= next_flt_s2;
			flt_s3     <= next_flt_s3;
			flt_stable <= next_flt_stable;
		end
	end

	// external time base synchroniser stages, idle level low
	always_ff @(posedge clk) begin
		if (!rstn) begin
			etb_s1     <= 1'b0;
			etb_s2     <= 1'b0;
			etb_s3     <= 1'b0;
			etb_stable <= 1'b0;
		end else if (ce) begin
			etb_s1     <= next_etb_s1;
			etb_s2     <= next_etb_s2;
			etb_s3     <= next_etb_s3;
			etb_stable <= next_etb_stable;
		end
	end

	// registered outputs
	always_ff @(posedge clk) begin
		if (!rstn) begin
			time_base_out        <= 1'b0;
			time_base_sel        <= 1'b0;
			debug_halt_behaviour <= tofc_pkg::RST_HALT;
			fault_active         <= 4'h0;
		end else if (ce) begin
			time_base_out        <= next_time_base_out;
			time_base_sel        <= next_time_base_sel;
			debug_halt_behaviour <= next_debug_halt_behaviour;
			fault_active         <= next_fault_active;
		end
	end
endmodule : tofc_top

/* File: tofc_assertions.sv */
// checker: port relations of the timer configuration block
`timescale 1ns/1ps
module tofc_checker (
	input wire logic                    clk,
	input wire logic                    rstn,
	input wire tofc_pkg::tofc_bus_req_t bus,
	input wire logic [31:0]             rdata,
	input wire logic                    cnt_overflow,
	input wire logic                    cnt_time_base,
	input wire logic [3:0]              fault_in,
	input wire logic                    overflow_flag,
	input wire logic                    time_base_out,
	input wire logic                    time_base_sel,
	input wire logic [1:0]              debug_halt_behaviour,
	input wire logic [3:0]              fault_active
);
	logic [10:0] sh;
	logic [4:0]  skip;
	logic [3:0]  pol;
	logic        wp;
	// shadow of config, protection, polarity and skip count
	always_ff @(posedge clk) begin
		if (!rstn) {sh, skip, pol, wp} <= '0;
		else begin
			if (bus.wr && bus.addr == tofc_pkg::ADDR_TIMER_CONFIG) sh <= bus.wdata[10:0];
			if (bus.wr && bus.addr == tofc_pkg::ADDR_CONTROL) wp <= bus.wdata[0];
			if (bus.wr && bus.addr == tofc_pkg::ADDR_FAULT_POLARITY && wp) pol <= bus.wdata[3:0];
			if (cnt_overflow) skip <= (skip == 5'h00) ? sh[4:0] : skip - 5'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// fault pins and polarity held still for a while
	sequence calm_s;
		($stable(fault_in) && $stable(pol)) [*6];
	endsequence
	ovf_skip_a: assert property (
		overflow_flag == $past(cnt_overflow && skip == 5'h00)) else $error("overflow skip wrong");
	tb_out_a: assert property (
		time_base_out == $past(sh[10] && cnt_time_base)) else $error("time base out wrong");
	ext_off_a: assert property (!$past(sh[9]) |-> !time_base_sel)
		else $error("external base not ignored");
	halt_sel_a: assert property (debug_halt_behaviour == sh[7:6])
		else $error("halt select wrong");
	fault_lvl_a: assert property (calm_s |-> fault_active == (fault_in ^ pol))
		else $error("fault level wrong");
	conf_read_a: assert property (
		$past(bus.rd && bus.addr == tofc_pkg::ADDR_TIMER_CONFIG) |->
		rdata == {21'h000000, $past(sh[10:9]), 1'b0, $past(sh[7:6]), 1'b0, $past(sh[4:0])})
		else $error("config read wrong");
	pol_read_a: assert property (
		$past(bus.rd && bus.addr == tofc_pkg::ADDR_FAULT_POLARITY) |->
		rdata == {28'h0000000, $past(pol)}) else $error("polarity read wrong");
	sync_resv_a: assert property (
		$past(bus.rd && bus.addr == tofc_pkg::ADDR_SYNC_CONFIG) |->
		rdata[31:21] == 11'h000) else $error("sync reserved bits set");
endmodule : tofc_checker
bind tofc_top tofc_checker u_chk (.clk, .rstn, .bus, .rdata, .cnt_overflow, .cnt_time_base,
	.fault_in, .overflow_flag, .time_base_out, .time_base_sel, .debug_halt_behaviour, .fault_active);

/* File: tofc_peer.sv */
// peer model: another timer instance driving its global time base
`timescale 1ns/1ps
module tofc_peer (
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic run,
	output logic      time_base
);
	logic [2:0] phase;
	// square wave, still while not running
	always_ff @(posedge clk) begin
		if (!rstn || !run) phase <= 3'h0;
		else phase <= phase + 3'h1;
	end
	assign time_base = phase[2];
endmodule : tofc_peer

/* File: tb.sv */
// testbench: registers, overflow ratio, time base enables, fault polarity
`timescale 1ns/1ps
module tb;
	logic                    clk, rstn, cnt_overflow, cnt_time_base, run, ext_tb, seen, irq;
	logic                    overflow_flag, time_base_out, time_base_sel;
	logic [1:0]              halt;
	logic [3:0]              fault_in, fault_active;
	logic [31:0]             rdata;
	tofc_pkg::tofc_bus_req_t bus;
	int                      n_errors, checks, flags;
	tofc_top dut (.clk, .rstn, .ce(1'b1), .bus, .rdata, .cnt_overflow, .cnt_time_base,
		.ext_time_base_in(ext_tb), .fault_in, .overflow_flag, .time_base_out, .time_base_sel,
		.debug_halt_behaviour(halt), .fault_active, .irq);
	tofc_peer peer (.clk, .rstn, .run, .time_base(ext_tb));
	// clock, flag counter and watchdog of about 40k cycles
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) if (overflow_flag === 1'b1) flags++;
	initial begin
		#2000000 n_errors++;
		conclude();
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		bus <= '0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus <= '{a, 32'h00000000, 1'b0, 1'b1};
		@(posedge clk);
		bus <= '0;
		#1 chk(rdata, e);
		@(posedge clk);
	endtask : rd
	task automatic rst;
		rstn <= 1'b0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
	endtask : rst
	task automatic t_regs;
		rd(tofc_pkg::ADDR_TIMER_CONFIG, 32'h00000000);
		wr(tofc_pkg::ADDR_TIMER_CONFIG, 32'hFFFFFFFF);
		rd(tofc_pkg::ADDR_TIMER_CONFIG, 32'h000006DF);
		wr(tofc_pkg::ADDR_SYNC_CONFIG, 32'hFFFFFFFF);
		rd(tofc_pkg::ADDR_SYNC_CONFIG, 32'h001FFFFF);
		rd(8'h20, 32'h00000000);
		for (int m = 0; m < 4; m++) begin
			wr(tofc_pkg::ADDR_TIMER_CONFIG, 32'(m) << 6);
			#1 chk({30'h00000000, halt}, 32'(m));
		end
	endtask : t_regs
	task automatic t_pol;
		fault_in <= 4'h5;
		wr(tofc_pkg::ADDR_FAULT_POLARITY, 32'hFFFFFFFF);
		rd(tofc_pkg::ADDR_FAULT_POLARITY, 32'h00000000);
		repeat (6) @(posedge clk);
		#1 chk({28'h0000000, fault_active}, 32'h00000005);
		rd(tofc_pkg::ADDR_IRQ_STATUS, 32'h00000002);
		wr(tofc_pkg::ADDR_CONTROL, 32'h00000001);
		rd(tofc_pkg::ADDR_CONTROL, 32'h00000001);
		wr(tofc_pkg::ADDR_FAULT_POLARITY, 32'hFFFFFFFF);
		rd(tofc_pkg::ADDR_FAULT_POLARITY, 32'h0000000F);
		repeat (6) @(posedge clk);
		#1 chk({28'h0000000, fault_active}, 32'h0000000A);
		fault_in <= 4'h0;
	endtask : t_pol
	task automatic t_ovf(input logic [4:0] n);
		rst();
		wr(tofc_pkg::ADDR_IRQ_MASK, 32'h00000001);
		wr(tofc_pkg::ADDR_TIMER_CONFIG, {27'h0000000, n});
		flags = 0;
		cnt_overflow <= 1'b1;
		repeat (2 * n + 3) @(posedge clk);
		cnt_overflow <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk(32'(flags), 32'h00000003);
		chk({31'h00000000, irq}, 32'h00000001);
		wr(tofc_pkg::ADDR_IRQ_STATUS, 32'h00000001);
		#1 chk({31'h00000000, irq}, 32'h00000000);
	endtask : t_ovf
	task automatic t_tb;
		cnt_time_base <= 1'b1;
		wr(tofc_pkg::ADDR_TIMER_CONFIG, 32'h00000400);
		#1 chk({31'h00000000, time_base_out}, 32'h00000001);
		wr(tofc_pkg::ADDR_TIMER_CONFIG, 32'h00000000);
		#1 chk({31'h00000000, time_base_out}, 32'h00000000);
		run <= 1'b1;
		repeat (20) @(posedge clk);
		#1 chk({31'h00000000, time_base_sel}, 32'h00000000);
		wr(tofc_pkg::ADDR_TIMER_CONFIG, 32'h00000200);
		seen = 1'b0;
		repeat (20) begin
			@(posedge clk);
			#1 seen = seen | time_base_sel;
		end
		chk({31'h00000000, seen}, 32'h00000001);
		rd(tofc_pkg::ADDR_IRQ_STATUS, 32'h00000004);
		run <= 1'b0;
	endtask : t_tb
	task automatic conclude;
		if (n_errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : conclude
	// main sequence
	initial begin
		rstn = 1'b0;
		bus = '0;
		cnt_overflow = 1'b0;
		cnt_time_base = 1'b0;
		fault_in = 4'h0;
		run = 1'b0;
		rst();
		t_regs();
		t_pol();
		t_ovf(5'h00);
		t_ovf(5'h01);
		t_ovf(5'h02);
		t_ovf(5'h1F);
		t_tb();
		conclude();
	end
endmodule : tb
